// ---- hw/cfg_read_pkg.sv ----
// Constants shared by both ends of the register read link
package cfg_read_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Command encoding on the rising edge (CA3..CA0)
  localparam logic [3:0] CMD_CFG_READ   = 4'h8;
  localparam logic [3:0] CMD_CFG_WRITE  = 4'h0;
  // Register addresses
  localparam logic [7:0] ADDR_TEMP      = 8'h04;
  localparam logic [7:0] ADDR_CAL_A     = 8'h20;
  localparam logic [7:0] ADDR_CAL_B     = 8'h28;
  // Calibration patterns, bit time 0 in bit 0
  localparam logic [3:0] PAT_A          = 4'h5;
  localparam logic [3:0] PAT_B          = 4'hc;
  // Latencies in clocks
  localparam int unsigned READ_LAT      = 3;
  localparam int unsigned WRITE_LAT     = 1;
  localparam int unsigned ACCESS_RU     = 1;
  localparam int unsigned BURST_BEATS   = 4;
  localparam int unsigned CMD_PERIOD    = 2;
  localparam int unsigned WTR_RU        = 1;
  localparam int unsigned BURST_LEN     = 4;
  // Spacing from a register read to a following write or register write
  localparam int unsigned READ_TO_WR    = READ_LAT + ACCESS_RU + BURST_BEATS / 2 + 1;
  // Spacing before a register read after READ or WRITE
  localparam int unsigned RD_TO_CFG     = BURST_LEN / 2;
  localparam int unsigned WR_TO_CFG     = WRITE_LAT + 1 + BURST_LEN / 2 + WTR_RU;
  // Sensor update interval
  localparam int unsigned SENSOR_MS     = 32;
  localparam int unsigned SENSOR_CYC    = SENSOR_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [2:0]  TEMP_RESET    = 3'h3;
  localparam int unsigned DQ_WIDTH      = 16;
endpackage : cfg_read_pkg

// ---- hw/cfg_read_if.sv ----
// Link between controller and device: DDR command bus and data with strobe
interface cfg_read_if;
  import cfg_read_pkg::*;
  logic                csN;
  logic [9:0]          caRise;
  logic [9:0]          caFall;
  logic [DQ_WIDTH-1:0] dq;
  logic                dqOe;
  logic [1:0]          dqs;
  logic                dqsOe;
  modport ctrl (output csN, output caRise, output caFall,
                input dq, input dqOe, input dqs, input dqsOe);
  modport dev  (input csN, input caRise, input caFall,
                output dq, output dqOe, output dqs, output dqsOe);
endinterface : cfg_read_if

// ---- hw/cfg_read_device.sv ----
// Device end: decodes register read commands and returns the burst
// How it works
// (RULE_01) Read decoded: CS low, CA3..0 = 1000
// (RULE_02) Address is fall CA1-0 with rise CA9-4
// (RULE_03) Byte on DQ7..0 first beat after latency
// (RULE_04) Other beats and upper lines undefined
// (RULE_05) Strobes toggle for whole burst
// (RULE_06) Burst is always four beats
// (RULE_07) Controller never interrupts a register read
// (RULE_08) Command period two clocks, NOPs only
// (RULE_09) Reserved registers return undefined, strobes toggle
// (RULE_10) Read to write spacing honoured by controller
// (RULE_11) Read to config write spacing by controller
// (RULE_12) Read waits half burst after READ
// (RULE_13) Read waits write spacing after WRITE
// (RULE_14) Stopped bursts use shortened length; the spacing here always uses the full BURST_LEN
// (RULE_15) Temperature status low three bits readable
// (RULE_16) Temperature status refreshed every 32 ms
// (RULE_17) Status after sleep no older than interval
// (RULE_18) Controller polls temperature often enough
// (RULE_19) Calibration A 1010, B 0011 all beats
// (RULE_20) Pattern on line zero of each byte
// (RULE_21) Other lines copy line zero
// (RULE_22) Calibration reads only while idle
// (RULE_23) Read allowed idle or active, state kept
module cfg_read_device
  import cfg_read_pkg::*;
#(
  parameter int unsigned SENSOR_CYCLES = SENSOR_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Link
  cfg_read_if.dev         link,
  // Sensor and bank state
  input  wire logic [2:0] tempSense,
  input  wire logic       bankActive,
  output logic            bankActiveSeen,
  output logic            busy
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_WAIT = 3'b010,
    S_BURST = 3'b100
  } state_t;

  typedef struct packed {
    state_t              state;
    logic [3:0]          cnt;
    logic [1:0]          beat;
    logic [7:0]          addr;
    logic [2:0]          temp;
    logic [31:0]         tick;
    logic [DQ_WIDTH-1:0] dq;
    logic                dqOe;
    logic [1:0]          dqs;
    logic                dqsOe;
    logic                bank;
    logic                busy;
    logic [8:0]          sync;
    logic [2:0]          sensed;
  } dev_t;

  dev_t s_q, s_d;

  // Byte returned on a given beat: fill for undefined, value for defined
  function automatic logic [DQ_WIDTH-1:0] beatData(input logic [7:0] a,
                                                  input logic [1:0] b,
                                                  input logic [2:0] t);
    logic [DQ_WIDTH-1:0] r;
    r = '0;
    if (a == ADDR_CAL_A) r = {DQ_WIDTH{PAT_A[b]}};             // RULE_19 RULE_20 RULE_21
    else if (a == ADDR_CAL_B) r = {DQ_WIDTH{PAT_B[b]}};        // RULE_19 RULE_20 RULE_21
    else if (b == 2'h0 && a == ADDR_TEMP) r = {13'h0000, t};   // RULE_15 RULE_03
    // Undefined beats and upper lines driven as zero, a valid level
    return r;                                                  // RULE_04 RULE_09
  endfunction : beatData

  // Next state
  always_comb begin
    s_d = s_q;
    // Sensor sampled through three flops; accepted when last two agree,
    // so a word caught mid-change never reaches the status register
    s_d.sync = {s_q.sync[5:0], tempSense};
    if (s_q.sync[5:3] == s_q.sync[8:6]) s_d.sensed = s_q.sync[8:6];
    s_d.tick = s_q.tick + 32'h1;
    if (s_q.tick >= SENSOR_CYCLES - 1) begin
      s_d.tick = '0;
      s_d.temp = s_q.sensed;                                   // RULE_16 RULE_17
    end
    s_d.bank = bankActive;                                     // RULE_23
    s_d.dqs = 2'h0;
    unique case (s_q.state)
      S_IDLE: begin
        s_d.dqOe = 1'b0;
        s_d.dqsOe = 1'b0;
        s_d.busy = 1'b0;
        if (!link.csN && link.caRise[3:0] == CMD_CFG_READ) begin  // RULE_01
          s_d.addr = {link.caRise[9:4], link.caFall[1:0]};        // RULE_02
          // Decode edge and burst launch edge both count toward the latency
          s_d.cnt = 4'(READ_LAT - 2);                          // RULE_03
          s_d.busy = 1'b1;
          s_d.state = S_WAIT;
        end
      end
      S_WAIT: begin
        s_d.cnt = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h0) begin
          s_d.beat = 2'h0;
          s_d.dq = beatData(s_q.addr, 2'h0, s_q.temp);         // RULE_03
          s_d.dqOe = 1'b1;
          s_d.dqsOe = 1'b1;
          s_d.dqs = 2'h1;                                      // RULE_05
          s_d.state = S_BURST;
        end
      end
      S_BURST: begin
        s_d.dqs = ~s_q.dqs;                                    // RULE_05
        s_d.beat = s_q.beat + 2'h1;
        s_d.dq = beatData(s_q.addr, s_q.beat + 2'h1, s_q.temp);
        if (s_q.beat == 2'(BURST_BEATS - 1)) begin             // RULE_06
          s_d.dqOe = 1'b0;
          s_d.dqsOe = 1'b0;
          s_d.dqs = 2'h0;
          s_d.busy = 1'b0;
          s_d.state = S_IDLE;
        end
      end
      default: s_d.state = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{state: S_IDLE, temp: TEMP_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign link.dq = s_q.dq;
  assign link.dqOe = s_q.dqOe;
  assign link.dqs = s_q.dqs;
  assign link.dqsOe = s_q.dqsOe;
  assign bankActiveSeen = s_q.bank;
  assign busy = s_q.busy;
endmodule : cfg_read_device

// ---- hw/cfg_read_ctrl.sv ----
// Controller end: issues register reads with the required spacing
module cfg_read_ctrl
  import cfg_read_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Link
  cfg_read_if.ctrl        link,
  // User request
  input  wire logic       reqValid,
  input  wire logic [7:0] reqAddr,
  input  wire logic       prevRead,
  input  wire logic       prevWrite,
  input  wire logic       deviceIdle,
  output logic            reqReady,
  output logic            rspValid,
  output logic [7:0]      rspData
);
  typedef enum logic [3:0] {
    C_IDLE = 4'b0001,
    C_CMD  = 4'b0010,
    C_DATA = 4'b0100,
    C_GAP  = 4'b1000
  } cstate_t;

  typedef struct packed {
    cstate_t    state;
    logic [3:0] cnt;
    logic [3:0] hold;
    logic [7:0] addr;
    logic       csN;
    logic [9:0] caR;
    logic [9:0] caF;
    logic       ready;
    logic       rsp;
    logic [7:0] data;
    logic       first;
  } ctl_t;

  ctl_t s_q, s_d;

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.rsp = 1'b0;
    s_d.csN = 1'b1;
    if (s_q.hold != 4'h0) s_d.hold = s_q.hold - 4'h1;
    if (prevRead) s_d.hold = 4'(RD_TO_CFG);                    // RULE_12 RULE_14
    if (prevWrite) s_d.hold = 4'(WR_TO_CFG);                   // RULE_13 RULE_14
    unique case (s_q.state)
      C_IDLE: begin
        s_d.ready = (s_q.hold == 4'h0);
        // Calibration addresses only go out while the device is idle
        if (reqValid && s_q.ready && s_q.hold == 4'h0 &&
            (deviceIdle || (reqAddr != ADDR_CAL_A && reqAddr != ADDR_CAL_B))) begin // RULE_22
          s_d.csN = 1'b0;
          s_d.caR = {reqAddr[7:2], CMD_CFG_READ};              // RULE_01 RULE_02
          s_d.caF = {8'h00, reqAddr[1:0]};                     // RULE_02
          s_d.ready = 1'b0;
          s_d.cnt = 4'(CMD_PERIOD - 1);
          s_d.state = C_CMD;
        end
      end
      C_CMD: begin
        // Only NOPs during the command period
        s_d.cnt = s_q.cnt - 4'h1;                              // RULE_08
        if (s_q.cnt == 4'h0) begin
          s_d.first = 1'b1;
          s_d.state = C_DATA;
        end
      end
      C_DATA: begin
        // No command until the burst is done
        if (link.dqsOe && s_q.first) begin                     // RULE_07
          s_d.data = link.dq[7:0];
          s_d.first = 1'b0;
        end
        if (!s_q.first && !link.dqsOe) begin
          s_d.rsp = 1'b1;
          s_d.cnt = 4'(READ_TO_WR - READ_LAT - BURST_BEATS / 2); // RULE_10 RULE_11
          s_d.state = C_GAP;
        end
      end
      C_GAP: begin
        s_d.cnt = s_q.cnt - 4'h1;                              // RULE_10 RULE_11
        if (s_q.cnt == 4'h0) begin
          s_d.state = C_IDLE;
        end
      end
      default: s_d.state = C_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{state: C_IDLE, csN: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign link.csN = s_q.csN;
  assign link.caRise = s_q.caR;
  assign link.caFall = s_q.caF;
  assign reqReady = s_q.ready;
  assign rspValid = s_q.rsp;
  assign rspData = s_q.data;
  // RULE_18: polling rate is the user's choice of reqValid timing
endmodule : cfg_read_ctrl

// ---- testbench/cfg_read_sva.sv ----
// Concurrent checks on the register read link between both ends
module cfg_read_sva
  import cfg_read_pkg::*;
(
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst,
  // Link signals
  input wire logic                csN,
  input wire logic [9:0]          caRise,
  input wire logic [9:0]          caFall,
  input wire logic [DQ_WIDTH-1:0] dq,
  input wire logic                dqOe,
  input wire logic [1:0]          dqs,
  input wire logic                dqsOe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Decoded command and its address, shared by the properties below
  wire logic       cmd  = !csN && caRise[3:0] == CMD_CFG_READ;
  wire logic [7:0] addr = {caRise[9:4], caFall[1:0]};
  sequence cmdS;
    cmd;
  endsequence
  // Pattern beats follow the burst start; all lines copy line zero
  sequence patS(logic [3:0] p);
    ##3 dq == {DQ_WIDTH{p[0]}} ##1 dq == {DQ_WIDTH{p[1]}}
    ##1 dq == {DQ_WIDTH{p[2]}} ##1 dq == {DQ_WIDTH{p[3]}};
  endsequence
  burst_latency_a: assert property (cmdS |-> ##3 $rose(dqOe))
    else $error("burst did not start three clocks after command");
  burst_four_a: assert property ($rose(dqOe) |-> dqOe[*4] ##1 !dqOe)
    else $error("burst length is not four beats");
  strobe_start_a: assert property ($rose(dqOe) |-> dqsOe && dqs == 2'h1)
    else $error("strobe not driven at burst start");
  strobe_toggle_a: assert property (dqOe && $past(dqOe) |-> dqsOe && dqs == ~$past(dqs))
    else $error("strobe did not toggle within burst");
  cmd_nop_a: assert property (cmdS |=> csN[*6])
    else $error("command issued too soon after register read");
  no_interrupt_a: assert property (dqOe |-> csN)
    else $error("command issued during burst");
  cal_a_pattern_a: assert property (cmd && addr == ADDR_CAL_A |-> patS(PAT_A))
    else $error("calibration pattern A wrong");
  cal_b_pattern_a: assert property (cmd && addr == ADDR_CAL_B |-> patS(PAT_B))
    else $error("calibration pattern B wrong");
endmodule : cfg_read_sva

// ---- testbench/sdram_mode_register_read_tb_top.sv ----
// Bench joining controller and device over the link
module sdram_mode_register_read_tb_top import cfg_read_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'h0;
  logic       rst = 1'h1;
  logic       reqValid = 1'h0, prevRead = 1'h0, prevWrite = 1'h0;
  logic       deviceIdle = 1'h1, bankActive = 1'h0;
  logic [7:0] reqAddr = 8'h0;
  logic [2:0] tempSense = 3'h6;
  wire logic  reqReady, rspValid, bankActiveSeen, busy;
  wire logic [7:0] rspData;
  int         mismatches = 0, n_compared = 0, cycles = 0;
  cfg_read_if link ();
  cfg_read_ctrl cfg_read_ctrl_inst (.clk, .rst, .link(link.ctrl), .reqValid, .reqAddr,
    .prevRead, .prevWrite, .deviceIdle, .reqReady, .rspValid, .rspData);
  // Short sensor interval keeps the update test quick
  cfg_read_device #(.SENSOR_CYCLES(16)) cfg_read_device_inst (.clk, .rst,
    .link(link.dev), .tempSense, .bankActive, .bankActiveSeen, .busy);
  cfg_read_sva cfg_read_sva_inst (.clk(clk), .rst(rst), .csN(link.csN), .caRise(link.caRise),
    .caFall(link.caFall), .dq(link.dq), .dqOe(link.dqOe), .dqs(link.dqs), .dqsOe(link.dqsOe));
  initial forever #50 clk = ~clk;
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Caller stands at a falling edge; lead counts clocks until the command
  task automatic read_reg(logic [7:0] addr, output logic [7:0] data, output int lead);
    int m;
    reqAddr = addr;
    reqValid = 1'h1;
    lead = 0;
    while (link.csN !== 1'h0 && lead < 100) begin
      @(negedge clk);
      lead++;
    end
    reqValid = 1'h0;
    check("address", addr, {link.caRise[9:4], link.caFall[1:0]});
    check("command", CMD_CFG_READ, link.caRise[3:0]);
    @(negedge clk);
    check("busy", 1'h1, busy);
    m = 0;
    while (rspValid !== 1'h1 && m < 100) begin
      @(negedge clk);
      m++;
    end
    data = rspData;
    check("busy end", 1'h0, busy);
    check("ready in gap", 1'h0, reqReady);
    @(negedge clk);
  endtask : read_reg
  task automatic t_temp();
    logic [7:0] d;
    int n;
    read_reg(ADDR_TEMP, d, n);
    check("temp reset", TEMP_RESET, d[2:0]);
    tempSense = 3'h5;
    repeat (40) @(negedge clk);
    read_reg(ADDR_TEMP, d, n);
    check("temp update", 3'h5, d[2:0]);
  endtask : t_temp
  // Calibration request must wait while the device is busy elsewhere
  task automatic t_calib();
    logic [7:0] d;
    logic seen;
    int n;
    deviceIdle = 1'h0;
    reqAddr = ADDR_CAL_A;
    reqValid = 1'h1;
    seen = 1'h0;
    repeat (20) begin
      @(negedge clk);
      seen |= !link.csN;
    end
    check("calib held", 1'h0, seen);
    deviceIdle = 1'h1;
    read_reg(ADDR_CAL_A, d, n);
    check("calib a", {8{PAT_A[0]}}, d);
    read_reg(ADDR_CAL_B, d, n);
    check("calib b", {8{PAT_B[0]}}, d);
  endtask : t_calib
  // Reserved address with banks open and closed
  task automatic t_bank(logic act);
    logic [7:0] d;
    int n;
    bankActive = act;
    read_reg(8'h7f, d, n);
    check("bank state", act, bankActiveSeen);
  endtask : t_bank
  task automatic t_spacing(logic rd, int gap);
    logic [7:0] d;
    int n;
    prevRead = rd;
    prevWrite = !rd;
    @(negedge clk);
    prevRead = 1'h0;
    prevWrite = 1'h0;
    read_reg(ADDR_TEMP, d, n);
    check("spacing", 1'h1, n >= gap);
  endtask : t_spacing
  task automatic stop_test();
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'h0;
    repeat (3) @(negedge clk);
    t_temp();
    t_calib();
    t_bank(1'h1);
    t_bank(1'h0);
    t_spacing(1'h1, RD_TO_CFG);
    t_spacing(1'h0, WR_TO_CFG);
    stop_test();
  end
endmodule : sdram_mode_register_read_tb_top
